// ---- sensor_port_pkg.sv ----
/*
 package for the sensor's two-wire target port: bus address, register map,
 command codes, reset values and the state types.
 assumes one 125 MHz clock and a synchronous active-high reset.
*/
// Behaviour
// - answer address 1110111; write EE, read EF
// - start is data falling while clock high
// - seven address bits, then direction bit
// - acknowledge own address on ninth pulse
// - stop is data rising while clock high
// - change data only while clock low
// - acknowledge every received byte of writes
// - 2E temperature; 34/74/B4/F4 pressure oversampling
// - register address in write sets pointer
// - calibration bytes readable at AA..BF
// - result bytes at F6, F7, F8
// - acknowledge read address after repeated start
// - send high byte first, MSB first
// - temperature 16 bits, pressure 16..19 bits
// - start bit 5 reads 1 while converting
// - bits 7:6 select pressure oversampling
// - B6 to E0 acts as power-on reset
package sensor_port_pkg;
    localparam logic [6:0] BUS_ADDRESS       = 7'h77;
    localparam logic [7:0] REG_CALIB_FIRST   = 8'hAA;
    localparam logic [7:0] REG_CALIB_LAST    = 8'hBF;
    localparam logic [7:0] REG_SOFT_RESET    = 8'hE0;
    localparam logic [7:0] REG_MEAS_CONTROL  = 8'hF4;
    localparam logic [7:0] REG_RESULT_HIGH   = 8'hF6;
    localparam logic [7:0] REG_RESULT_LOW    = 8'hF7;
    localparam logic [7:0] REG_RESULT_XLOW   = 8'hF8;
    localparam logic [7:0] SOFT_RESET_CODE   = 8'hB6;
    localparam logic [7:0] CMD_TEMPERATURE   = 8'h2E;
    localparam logic [4:0] CMD_PRESSURE_LOW  = 5'h14;
    localparam int         START_BIT_POS     = 5;
    localparam int         OSS_MSB_POS       = 7;
    localparam int         OSS_LSB_POS       = 6;
    localparam logic [7:0] CONTROL_RESET     = 8'h00;
    localparam logic [7:0] RESULT_HIGH_RESET = 8'h80;
    localparam logic [7:0] RESULT_LOW_RESET  = 8'h00;
    localparam logic [7:0] RESULT_XLOW_RESET = 8'h00;
    localparam int         CLOCK_MHZ         = 125;
    localparam real        CONV_US_OSS0      = 4500.0;
    localparam real        CONV_US_OSS1      = 7500.0;
    localparam real        CONV_US_OSS2      = 13500.0;
    localparam real        CONV_US_OSS3      = 25500.0;
    localparam int         CONV_CYCLES_OSS0  = int'(CONV_US_OSS0 * CLOCK_MHZ);
    localparam int         CONV_CYCLES_OSS1  = int'(CONV_US_OSS1 * CLOCK_MHZ);
    localparam int         CONV_CYCLES_OSS2  = int'(CONV_US_OSS2 * CLOCK_MHZ);
    localparam int         CONV_CYCLES_OSS3  = int'(CONV_US_OSS3 * CLOCK_MHZ);

    typedef enum logic [2:0] {
        ST_IDLE    = 3'b000,
        ST_ADDRESS = 3'b001,
        ST_ACK     = 3'b010,
        ST_WRITE   = 3'b011,
        ST_READ    = 3'b100,
        ST_RD_ACK  = 3'b101
    } port_state_t;

    typedef struct packed {
        logic       sda;
        logic       scl;
    } bus_pins_t;

    typedef struct packed {
        logic [18:0] word;
        logic        is_temp;
    } conv_result_t;
endpackage

// ---- pressure_sensor_i2c_port.sv ----
/*
 two-wire target port of the barometric sensor with its control and
 result registers and a conversion timer standing in for the converter.
 assumes open-drain wires resolved outside; scl and sda are asynchronous
 pins; raw conversion words come from the converter as a level input.
*/
`timescale 1ns/100ps
module pressure_sensor_i2c_port
    import sensor_port_pkg::*;
#(
    parameter int CONV_OSS0 = CONV_CYCLES_OSS0,
    parameter int CONV_OSS1 = CONV_CYCLES_OSS1,
    parameter int CONV_OSS2 = CONV_CYCLES_OSS2,
    parameter int CONV_OSS3 = CONV_CYCLES_OSS3
) (
    // clock and reset
    input  wire logic         clock,
    input  wire logic         reset,
    // two-wire bus
    input  wire logic         scl_in,
    input  wire logic         sda_in,
    output logic              sda_out,
    output logic              sda_oe,
    // converter and calibration store
    input  wire logic [15:0]  raw_temperature_word,
    input  wire logic [18:0]  raw_pressure_word,
    input  wire logic [175:0] calibration_bytes,
    output logic              conversion_busy
);
    typedef struct packed {
        logic [1:0]  scl_s;
        logic [1:0]  sda_s;
        logic        scl_q;
        logic        sda_q;
        port_state_t st;
        logic [3:0]  bits;
        logic [7:0]  shift;
        logic        rw;
        logic        got_reg;
        logic [7:0]  pointer;
        logic        drive_low;
        logic [7:0]  measurement_control_r;
        logic [7:0]  result_high_r;
        logic [7:0]  result_low_r;
        logic [7:0]  result_xlow_r;
        logic [24:0] timer;
    } state_t;

    state_t s_r;
    state_t s_nxt;
    logic   scl_v;
    logic   sda_v;
    logic   scl_rise;
    logic   scl_fall;
    logic   start_seen;
    logic   stop_seen;
    logic   own_addr;
    logic [7:0] read_data;
    logic [7:0] cal_idx;
    logic [1:0] oss;

    assign scl_v      = s_r.scl_s[1];
    assign sda_v      = s_r.sda_s[1];
    assign scl_rise   = scl_v && !s_r.scl_q;
    assign scl_fall   = !scl_v && s_r.scl_q;
    assign start_seen = scl_v && s_r.scl_q && s_r.sda_q && !sda_v;
    assign stop_seen  = scl_v && s_r.scl_q && !s_r.sda_q && sda_v;
    assign own_addr   = (s_r.shift[7:1] == BUS_ADDRESS);
    assign oss        = s_r.measurement_control_r[OSS_MSB_POS:OSS_LSB_POS];
    assign cal_idx    = s_r.pointer - REG_CALIB_FIRST;

    // register read mux
    always_comb begin
        read_data = 8'h00;
        if (s_r.pointer >= REG_CALIB_FIRST && s_r.pointer <= REG_CALIB_LAST) begin
            read_data = calibration_bytes[cal_idx[4:0]*8 +: 8];
        end else begin
            unique case (s_r.pointer)
                REG_MEAS_CONTROL: read_data = s_r.measurement_control_r;
                REG_RESULT_HIGH:  read_data = s_r.result_high_r;
                REG_RESULT_LOW:   read_data = s_r.result_low_r;
                REG_RESULT_XLOW:  read_data = s_r.result_xlow_r;
                default:          read_data = 8'h00;
            endcase
        end
    end

    always_comb begin
        s_nxt       = s_r;
        s_nxt.scl_s = {s_r.scl_s[0], scl_in};
        s_nxt.sda_s = {s_r.sda_s[0], sda_in};
        s_nxt.scl_q = scl_v;
        s_nxt.sda_q = sda_v;

        // conversion timer; busy bit clears in the same cycle the results are loaded
        if (s_r.timer != 25'd0) begin
            s_nxt.timer = s_r.timer - 25'd1;
            if (s_r.timer == 25'd1) begin
                s_nxt.measurement_control_r[START_BIT_POS] = 1'b0;
                if (s_r.measurement_control_r[4:0] == CMD_TEMPERATURE[4:0]) begin
                    s_nxt.result_high_r = raw_temperature_word[15:8];
                    s_nxt.result_low_r  = raw_temperature_word[7:0];
                    s_nxt.result_xlow_r = 8'h00;
                end else begin
                    s_nxt.result_high_r = raw_pressure_word[18:11];
                    s_nxt.result_low_r  = raw_pressure_word[10:3];
                    s_nxt.result_xlow_r = {raw_pressure_word[2:0], 5'b0_0000};
                end
            end
        end

        if (stop_seen) begin
            s_nxt.st        = ST_IDLE;
            s_nxt.drive_low = 1'b0;
        end else if (start_seen) begin // repeated start keeps the pointer
            s_nxt.st        = ST_ADDRESS;
            s_nxt.bits      = 4'd0;
            s_nxt.drive_low = 1'b0;
            s_nxt.got_reg   = 1'b0;
        end else begin
            unique case (s_r.st)
                ST_IDLE: begin
                end
                ST_ADDRESS, ST_WRITE: begin
                    if (scl_rise) begin
                        s_nxt.shift = {s_r.shift[6:0], sda_v};
                        s_nxt.bits  = s_r.bits + 4'd1;
                    end
                    if (scl_fall && s_r.bits == 4'd8) begin
                        s_nxt.bits = 4'd0;
                        if (s_r.st == ST_ADDRESS) begin
                            if (own_addr) begin
                                s_nxt.rw        = s_r.shift[0];
                                s_nxt.drive_low = 1'b1;
                                s_nxt.st        = ST_ACK;
                            end else begin
                                s_nxt.st = ST_IDLE;
                            end
                        end else begin
                            s_nxt.drive_low = 1'b1;
                            s_nxt.st        = ST_ACK;
                            if (!s_r.got_reg) begin
                                s_nxt.pointer = s_r.shift;
                                s_nxt.got_reg = 1'b1;
                            end else begin
                                s_nxt.pointer = s_r.pointer + 8'd1;
                                if (s_r.pointer == REG_MEAS_CONTROL) begin
                                    s_nxt.measurement_control_r = s_r.shift | 8'h20;
                                    unique case (s_r.shift[OSS_MSB_POS:OSS_LSB_POS])
                                        2'd0: s_nxt.timer = 25'(CONV_OSS0);
                                        2'd1: s_nxt.timer = 25'(CONV_OSS1);
                                        2'd2: s_nxt.timer = 25'(CONV_OSS2);
                                        2'd3: s_nxt.timer = 25'(CONV_OSS3);
                                    endcase
                                    if (s_r.shift == CMD_TEMPERATURE) begin
                                        s_nxt.timer = 25'(CONV_OSS0);
                                    end
                                end
                                if (s_r.pointer == REG_SOFT_RESET && s_r.shift == SOFT_RESET_CODE) begin
                                    s_nxt.measurement_control_r = CONTROL_RESET;
                                    s_nxt.result_high_r         = RESULT_HIGH_RESET;
                                    s_nxt.result_low_r          = RESULT_LOW_RESET;
                                    s_nxt.result_xlow_r         = RESULT_XLOW_RESET;
                                    s_nxt.timer                 = 25'd0;
                                end
                            end
                        end
                    end
                end
                ST_ACK: begin
                    if (scl_fall) begin // release only while clock low
                        s_nxt.drive_low = 1'b0;
                        if (s_r.rw) begin
                            s_nxt.st        = ST_READ;
                            s_nxt.shift     = read_data;
                            s_nxt.drive_low = !read_data[7];
                            s_nxt.bits      = 4'd1;
                            s_nxt.pointer   = s_r.pointer + 8'd1;
                        end else begin
                            s_nxt.st = ST_WRITE;
                        end
                    end
                end
                ST_READ: begin
                    if (scl_fall) begin
                        if (s_r.bits == 4'd8) begin
                            s_nxt.drive_low = 1'b0;
                            s_nxt.st        = ST_RD_ACK;
                        end else begin
                            s_nxt.drive_low = !s_r.shift[6];
                            s_nxt.shift     = {s_r.shift[6:0], 1'b0};
                            s_nxt.bits      = s_r.bits + 4'd1;
                        end
                    end
                end
                ST_RD_ACK: begin
                    if (scl_rise) begin
                        s_nxt.rw = !sda_v; // no-ack ends the burst
                    end
                    if (scl_fall) begin
                        if (s_r.rw) begin
                            s_nxt.st        = ST_READ;
                            s_nxt.shift     = read_data;
                            s_nxt.drive_low = !read_data[7];
                            s_nxt.bits      = 4'd1;
                            s_nxt.pointer   = s_r.pointer + 8'd1;
                        end else begin
                            s_nxt.st = ST_IDLE;
                        end
                    end
                end
                // codes 110 and 111 cannot be reached; recover to idle if upset
                default: s_nxt.st = ST_IDLE;
            endcase
        end
    end

    always_ff @(posedge clock) begin
        if (reset) begin
            s_r                       <= '0;
            s_r.scl_s                 <= 2'b11;
            s_r.sda_s                 <= 2'b11;
            s_r.scl_q                 <= 1'b1;
            s_r.sda_q                 <= 1'b1;
            s_r.st                    <= ST_IDLE;
            s_r.measurement_control_r <= CONTROL_RESET;
            s_r.result_high_r         <= RESULT_HIGH_RESET;
        end else begin
            s_r <= s_nxt;
        end
    end

    assign sda_out         = 1'b0;
    assign sda_oe          = s_r.drive_low;
    assign conversion_busy = s_r.measurement_control_r[START_BIT_POS];

    property p_ack_addr;
        @(posedge clock) disable iff (reset)
        (s_r.st == ST_ADDRESS && scl_fall && s_r.bits == 4'd8 && own_addr && !start_seen && !stop_seen)
            |=> (sda_oe && s_r.st == ST_ACK);
    endproperty
    a_ack_addr: assert property (p_ack_addr) else $error("own address not acknowledged");

    property p_no_ack_foreign;
        @(posedge clock) disable iff (reset)
        (s_r.st == ST_ADDRESS && scl_fall && s_r.bits == 4'd8 && !own_addr && !start_seen && !stop_seen)
            |=> (!sda_oe && s_r.st == ST_IDLE);
    endproperty
    a_no_ack_foreign: assert property (p_no_ack_foreign) else $error("foreign address acknowledged");

    property p_stable_high;
        @(posedge clock) disable iff (reset)
        (scl_v && s_r.scl_q && !stop_seen && !start_seen) |=> $stable(sda_oe);
    endproperty
    a_stable_high: assert property (p_stable_high) else $error("data changed while clock high");

    property p_stop_idle;
        @(posedge clock) disable iff (reset)
        stop_seen |=> (s_r.st == ST_IDLE && !sda_oe);
    endproperty
    a_stop_idle: assert property (p_stop_idle) else $error("stop did not release bus");

    property p_start_addr;
        @(posedge clock) disable iff (reset)
        (start_seen && !stop_seen) |=> (s_r.st == ST_ADDRESS && s_r.bits == 4'd0);
    endproperty
    a_start_addr: assert property (p_start_addr) else $error("start not recognised");

    sequence s_busy_done;
        (s_r.timer == 25'd1) ##1 !conversion_busy;
    endsequence
    property p_busy_clear;
        @(posedge clock) disable iff (reset)
        (s_r.timer == 25'd1) |-> s_busy_done or (##1 s_r.timer != 25'd0);
    endproperty
    a_busy_clear: assert property (p_busy_clear) else $error("busy bit not cleared");

    property p_busy_while_timing;
        @(posedge clock) disable iff (reset)
        (s_r.timer > 25'd1) |-> conversion_busy;
    endproperty
    a_busy_while_timing: assert property (p_busy_while_timing) else $error("busy low during conversion");

    // checks the stored setting, not the incoming byte the timer was loaded from
    property p_conv_length;
        @(posedge clock) disable iff (reset)
        $rose(conversion_busy) |->
            (s_r.timer == ((s_r.measurement_control_r == CMD_TEMPERATURE) ? 25'(CONV_OSS0) :
                           (oss == 2'd0) ? 25'(CONV_OSS0) : (oss == 2'd1) ? 25'(CONV_OSS1) :
                           (oss == 2'd2) ? 25'(CONV_OSS2) : 25'(CONV_OSS3)));
    endproperty
    a_conv_length: assert property (p_conv_length) else $error("conversion length not set by oversampling");

    property p_read_msb;
        @(posedge clock) disable iff (reset)
        (s_r.st == ST_ACK && scl_fall && s_r.rw && !start_seen && !stop_seen)
            |=> (sda_oe == !$past(read_data[7]) && s_r.pointer == $past(s_r.pointer) + 8'd1);
    endproperty
    a_read_msb: assert property (p_read_msb) else $error("first read bit or pointer wrong");

    property p_write_ack;
        @(posedge clock) disable iff (reset)
        (s_r.st == ST_WRITE && scl_fall && s_r.bits == 4'd8 && !start_seen && !stop_seen)
            |=> sda_oe;
    endproperty
    a_write_ack: assert property (p_write_ack) else $error("written byte not acknowledged");
endmodule

// ---- i2c_master_model.sv ----
/*
 two-wire bus master model, the far side of the sensor port.
 assumes the bench resolves the wired data line; scl idles high.
*/
`timescale 1ns/100ps
module i2c_master_model (
    // clock
    input  wire logic clock,
    // two-wire bus
    input  wire logic sda_bus,
    output logic      scl_drive,
    output logic      sda_pull
);
    logic [7:0] rd [0:31];
    logic [2:0] ak;
    initial {scl_drive, sda_pull} = 2'b10;
    // a quarter of the 160 ns bus period
    task automatic q;
        repeat (5) @(negedge clock);
    endtask
    task automatic drv(input logic c, input logic p);
        scl_drive = c;
        sda_pull  = p;
        q;
    endtask
    // from idle this adds no stray clock pulse
    task automatic start_cond;
        drv(scl_drive, 1'b0);
        drv(1'b1, 1'b0);
        drv(1'b1, 1'b1);
        scl_drive = 1'b0;
    endtask
    task automatic stop_cond;
        drv(1'b0, sda_pull);
        drv(1'b0, 1'b1);
        drv(1'b1, 1'b1);
        drv(1'b1, 1'b0);
    endtask
    // data moves a quarter period after scl falls
    task automatic bit_xfer(input logic b, output logic s);
        drv(1'b0, sda_pull);
        drv(1'b0, ~b);
        drv(1'b1, ~b);
        s = sda_bus;
        drv(1'b1, ~b);
        scl_drive = 1'b0;
    endtask
    task automatic send_byte(input logic [7:0] b, output logic a);
        logic s;
        for (int i = 7; i >= 0; i--) bit_xfer(b[i], s);
        bit_xfer(1'b1, s);
        a = ~s;
    endtask
    task automatic reg_write(input logic [7:0] dev, input logic [7:0] r, input logic [7:0] v);
        start_cond;
        send_byte(dev, ak[2]);
        send_byte(r, ak[1]);
        send_byte(v, ak[0]);
        stop_cond;
    endtask
    // the last byte is refused so the port lets go before the stop
    task automatic reg_read(input logic [7:0] r, input int n);
        logic s;
        start_cond;
        send_byte(8'hEE, ak[2]);
        send_byte(r, ak[1]);
        start_cond;
        send_byte(8'hEF, ak[0]);
        for (int i = 0; i < n; i++) begin
            for (int j = 7; j >= 0; j--) begin
                bit_xfer(1'b1, s);
                rd[i][j] = s;
            end
            bit_xfer(i == n - 1, s);
        end
        stop_cond;
    endtask
endmodule

// ---- pressure_sensor_i2c_port_tb.sv ----
/*
 bench for the sensor two-wire port; a master model works the wires.
 assumes the port's hand-over timing and the package constants.
*/
`timescale 1ns/100ps
module pressure_sensor_i2c_port_tb;
    import sensor_port_pkg::*;
    // conversion counts cut short so the run stays brief
    localparam int BASE = 1500;
    localparam int STEP = 500;
    logic         clock = 1'b0;
    logic         reset = 1'b1;
    logic         scl, pull, sda, sda_oe, sda_drv, busy, busy_q;
    logic [15:0]  t_word = '0;
    logic [18:0]  p_word = '0;
    logic [175:0] calib;
    logic [7:0]   cmds [5];
    int           fail_count = 0;
    int           n_compared = 0;
    int           seed = 76062;
    int           busy_len = 0;
    int           left;
    // open-drain wire with pull-up: low only where a side enables a low level
    assign sda = !pull && !(sda_oe && !sda_drv);
    always #4 clock = ~clock;
    pressure_sensor_i2c_port #(.CONV_OSS0(BASE), .CONV_OSS1(BASE + STEP),
        .CONV_OSS2(BASE + 2 * STEP), .CONV_OSS3(BASE + 3 * STEP)) DUT (
        .clock(clock), .reset(reset), .scl_in(scl), .sda_in(sda), .sda_out(sda_drv), .sda_oe(sda_oe),
        .raw_temperature_word(t_word), .raw_pressure_word(p_word),
        .calibration_bytes(calib), .conversion_busy(busy));
    i2c_master_model m (.clock(clock), .sda_bus(sda), .scl_drive(scl), .sda_pull(pull));
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        n_compared++;
        if (seen !== exp) begin
            fail_count++;
            $display("mismatch at %0t seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic close_out;
        $display("compared %0d mismatches %0d", n_compared, fail_count);
        if (fail_count == 0 && n_compared > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask
    function automatic int conv_of(input logic [7:0] cmd);
        return BASE + STEP * int'(cmd[7:6]);
    endfunction
    // control and the three result bytes in one burst
    task automatic reset_values;
        m.reg_read(REG_MEAS_CONTROL, 5);
        check(m.ak, 3'b111);
        check({m.rd[0], m.rd[2], m.rd[3], m.rd[4]},
              {CONTROL_RESET, RESULT_HIGH_RESET, RESULT_LOW_RESET, RESULT_XLOW_RESET});
    endtask
    // length of the last busy period, held after it ends
    always @(posedge clock) begin
        busy_q <= busy;
        if (busy && !busy_q) busy_len <= 1;
        else if (busy) busy_len <= busy_len + 1;
    end
    initial begin
        cmds = '{CMD_TEMPERATURE, 8'h34, 8'h74, 8'hB4, 8'hF4};
        for (int i = 0; i < 6; i++) calib = {calib[143:0], 32'($random(seed))};
        repeat (20) @(negedge clock);
        reset = 1'b0;
        repeat (8) @(negedge clock);
        reset_values;
        $display("done: reset values");
        // foreign addresses, both directions, stay unanswered
        for (int i = 0; i < 4; i++) begin
            m.reg_write({BUS_ADDRESS ^ (7'($random(seed)) | 7'h01), i[0]}, REG_MEAS_CONTROL, CMD_TEMPERATURE);
            check({m.ak, busy}, 4'h0);
        end
        m.reg_write(8'hEE, REG_CALIB_FIRST, 8'h5A);
        check(m.ak, 3'b111);
        $display("done: addressing");
        foreach (cmds[k]) begin
            t_word = 16'($random(seed));
            p_word = 19'($random(seed));
            m.reg_write(8'hEE, REG_MEAS_CONTROL, cmds[k]);
            check(m.ak, 3'b111);
            m.reg_read(REG_MEAS_CONTROL, 1);
            check({m.ak, m.rd[0], busy}, {3'b111, cmds[k], 1'b1});
            for (left = 0; busy === 1'b1 && left < 40000; left++) @(negedge clock);
            if (left >= 40000) begin
                fail_count++;
                close_out;
            end
            check(busy_len >= conv_of(cmds[k]) - 8 && busy_len <= conv_of(cmds[k]) + 8, 1'b1);
            m.reg_read(REG_MEAS_CONTROL, 5);
            check({m.rd[0], m.rd[1]}, {cmds[k] & 8'hDF, 8'h00});
            if (cmds[k] == CMD_TEMPERATURE) check({m.rd[2], m.rd[3]}, t_word);
            else check({m.rd[2], m.rd[3], m.rd[4]}, {p_word, 5'b0});
            $display("done: measurement %h", cmds[k]);
        end
        // calibration burst runs one past the end into unmapped space
        m.reg_read(REG_CALIB_FIRST, 23);
        for (int k = 0; k < 22; k++) check(m.rd[k], calib[8*k +: 8]);
        check(m.rd[22], 8'h00);
        $display("done: calibration");
        m.reg_write(8'hEE, REG_SOFT_RESET, SOFT_RESET_CODE);
        check(m.ak, 3'b111);
        reset_values;
        $display("done: soft reset");
        close_out;
    end
endmodule
